// ---- design/boot_strap_latch.sv ----
// captures the boot straps at reset exit and decodes the clock and boot modes
`timescale 1ns/10ps
`include "reset_boot_params.svh"
module boot_strap_latch (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // strap levels
  input  wire logic [1:0] clock_boot_select,
  input  wire logic       crystal_pin_in,
  input  wire logic       reset_config_n,
  input  wire logic       test_in,
  // decoded modes
  boot_mode_if.strap      mode
);

  logic [1:0] sel_ff;
  logic       crystal_pin_ff;
  logic       flash_ff;

  function automatic reset_boot_pkg::clock_source_e decode_source(input logic [1:0] sel,
                                                                  input logic       crystal_pin);
    if (sel[0]) begin
      decode_source = reset_boot_pkg::CLK_SRC_CRYSTAL;
    end else if (crystal_pin) begin
      decode_source = reset_boot_pkg::CLK_SRC_ONCHIP;
    end else begin
      decode_source = reset_boot_pkg::CLK_SRC_EXTERNAL;
    end
  endfunction

  // modes stay frozen between captures so the clock tree never switches live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff   <= `BOOT_SEL_DIRECT;
      crystal_pin_ff  <= 1'b0;
      flash_ff <= 1'b0;
    end else if (mode.capture) begin
      sel_ff   <= clock_boot_select;
      crystal_pin_ff  <= crystal_pin_in;
      flash_ff <= !reset_config_n && !test_in;
    end
  end

  assign mode.boot_sel        = sel_ff;
  assign mode.crystal_level   = crystal_pin_ff;
  assign mode.pll_enable      = sel_ff[1];
  assign mode.clock_source    = decode_source(sel_ff, crystal_pin_ff);
  assign mode.flash_prog_mode = flash_ff;
endmodule

// ---- design/reset_and_clock_boot_select.sv ----
// top of the reset and clock boot select block with its apb register slave
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "reset_boot_params.svh"
module reset_and_clock_boot_select (
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // reset pins
  input  wire logic        reset_in_n,
  output logic             reset_out_n,
  output logic             core_reset_n,
  // boot straps
  input  wire logic [1:0]  clock_boot_select,
  input  wire logic        reset_config_n,
  input  wire logic        test_in,
  // crystal pin, split into three signals
  input  wire logic        crystal_pin_in,
  output logic             crystal_pin_out,
  output logic             crystal_pin_oe,
  // oscillator levels
  input  wire logic        osc_amp_level,
  input  wire logic        external_clock_in,
  input  wire logic        onchip_osc_level,
  input  wire logic        crystal_osc_level,
  input  wire logic        sys_clock_level,
  // clock and boot outputs
  output logic             pll_enable,
  output logic [1:0]       clock_source,
  output logic             ref_clock_level,
  output logic             system_clock_out,
  output logic             flash_prog_mode
);

  boot_mode_if mode_bus ();

  logic                     ctrl_sw_reset_ff;
  logic                     sw_reset_pulse_ff;
  logic [`RSTOUT_CNT_W-1:0] stretch_count;
  logic                     reset_out_n_w;
  logic                     core_reset_n_w;
  logic                     ref_clock_ff;
  logic                     sys_clock_ff;
  logic [31:0]              rd_data;
  logic                     addr_hit;
  logic                     apb_write;
  logic                     apb_read;
  logic                     sel_bit1_now;

  // apb decode ------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] addr);
    reg_hit = (addr[31:`REG_ADDR_W] == 24'h00_0000) &&
              ((addr[`REG_ADDR_W-1:0] == `REG_CTRL_OFS) ||
               (addr[`REG_ADDR_W-1:0] == `REG_STATUS_OFS) ||
               (addr[`REG_ADDR_W-1:0] == `REG_STRETCH_OFS));
  endfunction

  assign addr_hit  = reg_hit(paddr);
  assign apb_write = psel && penable && pwrite && addr_hit;
  // setup cycle of a read: the data register is loaded here so it stands for the access
  assign apb_read  = psel && !penable && !pwrite;
  // every access completes in its first access cycle
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_hit;

  // software reset request: one write of 1 raises a single-cycle reset source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_sw_reset_ff <= 1'b0;
    end else if (apb_write && (paddr[`REG_ADDR_W-1:0] == `REG_CTRL_OFS)) begin
      ctrl_sw_reset_ff <= pwdata[`CTRL_SW_RESET_BIT];
    end else begin
      ctrl_sw_reset_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reset_pulse_ff <= 1'b0;
    end else begin
      sw_reset_pulse_ff <= ctrl_sw_reset_ff;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (paddr[`REG_ADDR_W-1:0])
      `REG_CTRL_OFS: begin
        rd_data[`CTRL_SW_RESET_BIT] = ctrl_sw_reset_ff;
      end
      `REG_STATUS_OFS: begin
        rd_data[`STAT_RESET_OUT_BIT]              = reset_out_n_w;
        rd_data[`STAT_CORE_RESET_BIT]             = core_reset_n_w;
        rd_data[`STAT_PLL_EN_BIT]                 = mode_bus.pll_enable;
        rd_data[`STAT_SRC_MSB:`STAT_SRC_LSB]      = mode_bus.clock_source;
        rd_data[`STAT_FLASH_PROG_BIT]             = mode_bus.flash_prog_mode;
        rd_data[`STAT_SEL_MSB:`STAT_SEL_LSB]      = mode_bus.boot_sel;
        rd_data[`STAT_CRYSTAL_PIN_BIT]                   = mode_bus.crystal_level;
      end
      `REG_STRETCH_OFS: begin
        rd_data[`RSTOUT_CNT_W-1:0] = stretch_count;
      end
      default: rd_data = 32'h0000_0000;
    endcase
    if (!addr_hit) begin
      rd_data = 32'h0000_0000;
    end
  end

  // read data held in a flop; updated only on the setup cycle of a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_read) begin
      prdata <= rd_data;
    end
  end

  // reset sequencing and strap capture -----------------------------------
  reset_sequencer u_seq (
    .pclk          (pclk),
    .presetn       (presetn),
    .reset_in_n    (reset_in_n),
    .sw_reset      (sw_reset_pulse_ff),
    .core_reset_n  (core_reset_n_w),
    .reset_out_n   (reset_out_n_w),
    .stretch_count (stretch_count),
    .mode          (mode_bus.sequencer)
  );

  boot_strap_latch u_strap (
    .pclk              (pclk),
    .presetn           (presetn),
    .clock_boot_select (clock_boot_select),
    .crystal_pin_in    (crystal_pin_in),
    .reset_config_n    (reset_config_n),
    .test_in           (test_in),
    .mode              (mode_bus.strap)
  );

  assign reset_out_n  = reset_out_n_w;
  assign core_reset_n = core_reset_n_w;

  // crystal pin direction: live strap while reset holds, latched strap after
  assign sel_bit1_now    = mode_bus.in_reset ? clock_boot_select[1] : mode_bus.boot_sel[1];
  assign crystal_pin_oe  = !sel_bit1_now;
  assign crystal_pin_out = osc_amp_level;

  assign pll_enable      = mode_bus.pll_enable;
  assign clock_source    = mode_bus.clock_source;
  assign flash_prog_mode = mode_bus.flash_prog_mode;

  // reference clock level; the external pin is never looked at for on-chip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clock_ff <= 1'b0;
    end else begin
      unique case (mode_bus.clock_source)
        reset_boot_pkg::CLK_SRC_ONCHIP:   ref_clock_ff <= onchip_osc_level;
        reset_boot_pkg::CLK_SRC_CRYSTAL:  ref_clock_ff <= crystal_osc_level;
        reset_boot_pkg::CLK_SRC_EXTERNAL: ref_clock_ff <= external_clock_in;
        default:                          ref_clock_ff <= 1'b0;
      endcase
    end
  end

  assign ref_clock_level = ref_clock_ff;

  // sampled copy: one cycle late, and only faithful for a clock well below pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clock_ff <= 1'b0;
    end else begin
      sys_clock_ff <= sys_clock_level;
    end
  end

  assign system_clock_out = sys_clock_ff;
endmodule

// ---- design/reset_sequencer.sv ----
// reset input filter, reset hold and reset output stretch
`timescale 1ns/10ps
`include "reset_boot_params.svh"
module reset_sequencer (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // reset sources
  input  wire logic                       reset_in_n,
  input  wire logic                       sw_reset,
  // reset outputs
  output logic                            core_reset_n,
  output logic                            reset_out_n,
  output logic [`RSTOUT_CNT_W-1:0]        stretch_count,
  // towards the strap latch
  boot_mode_if.sequencer                  mode
);

  reset_boot_pkg::seq_state_e state_ff;
  reset_boot_pkg::seq_state_e nxt_state;
  logic [`RSTIN_CNT_W-1:0]    low_cnt_ff;
  logic [`RSTOUT_CNT_W-1:0]   stretch_ff;
  logic                       source_active;

  // a glitch shorter than the minimum never reaches the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_ff <= 4'h0;
    end else if (reset_in_n) begin
      low_cnt_ff <= 4'h0;
    end else if (low_cnt_ff != `RSTIN_MIN_CYCLES) begin
      low_cnt_ff <= low_cnt_ff + 4'h1;
    end
  end

  assign source_active = (low_cnt_ff == `RSTIN_MIN_CYCLES) || sw_reset;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      reset_boot_pkg::SEQ_HOLD: begin
        if (!source_active) begin
          nxt_state = reset_boot_pkg::SEQ_STRETCH;
        end
      end
      reset_boot_pkg::SEQ_STRETCH: begin
        if (source_active) begin
          nxt_state = reset_boot_pkg::SEQ_HOLD;
        end else if (stretch_ff == `RSTOUT_STRETCH_CYCLES - 11'h1) begin
          nxt_state = reset_boot_pkg::SEQ_RUN;
        end
      end
      reset_boot_pkg::SEQ_RUN: begin
        if (source_active) begin
          nxt_state = reset_boot_pkg::SEQ_HOLD;
        end
      end
      default: nxt_state = reset_boot_pkg::SEQ_HOLD;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= reset_boot_pkg::SEQ_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stretch_ff <= 11'h000;
    end else if (state_ff != reset_boot_pkg::SEQ_STRETCH) begin
      stretch_ff <= 11'h000;
    end else begin
      stretch_ff <= stretch_ff + 11'h001;
    end
  end

  assign core_reset_n  = (state_ff != reset_boot_pkg::SEQ_HOLD);
  assign reset_out_n   = (state_ff == reset_boot_pkg::SEQ_RUN);
  assign stretch_count = stretch_ff;
  assign mode.in_reset = (state_ff == reset_boot_pkg::SEQ_HOLD);
  // straps are taken on the last cycle of the held reset
  assign mode.capture  = (state_ff == reset_boot_pkg::SEQ_HOLD) && !source_active;
endmodule

// ---- shared/boot_mode_if.sv ----
// carrier between the reset sequencer, the strap latch and the top
`timescale 1ns/10ps
interface boot_mode_if;
  logic                        capture;
  logic                        in_reset;
  logic                        pll_enable;
  reset_boot_pkg::clock_source_e clock_source;
  logic                        flash_prog_mode;
  logic [1:0]                  boot_sel;
  logic                        crystal_level;

  modport sequencer (output capture, output in_reset);
  modport strap (input capture, input in_reset, output pll_enable, output clock_source,
                 output flash_prog_mode, output boot_sel, output crystal_level);
  modport consumer (input capture, input in_reset, input pll_enable, input clock_source,
                    input flash_prog_mode, input boot_sel, input crystal_level);
endinterface

// ---- shared/reset_boot_params.svh ----
// offsets, field positions, reset values and cycle counts of the reset and boot block
`ifndef RESET_BOOT_PARAMS_SVH
`define RESET_BOOT_PARAMS_SVH

// apb register byte offsets
`define REG_CTRL_OFS          8'h00
`define REG_STATUS_OFS        8'h04
`define REG_STRETCH_OFS       8'h08
`define REG_ADDR_W            8

// control register fields
`define CTRL_SW_RESET_BIT     0
`define CTRL_RESET_VAL        32'h0000_0000

// status register fields
`define STAT_RESET_OUT_BIT    0
`define STAT_CORE_RESET_BIT   1
`define STAT_PLL_EN_BIT       2
`define STAT_SRC_LSB          3
`define STAT_SRC_MSB          4
`define STAT_FLASH_PROG_BIT   5
`define STAT_SEL_LSB          6
`define STAT_SEL_MSB          7
`define STAT_CRYSTAL_PIN_BIT         8

// cycle counts
`define RSTIN_MIN_CYCLES      4'h8
`define RSTIN_CNT_W           4
`define RSTOUT_STRETCH_CYCLES 11'h400
`define RSTOUT_CNT_W          11

// strap encodings of the clock boot select
`define BOOT_SEL_DIRECT       2'h0
`define BOOT_SEL_CRYSTAL_PIN         2'h1
`define BOOT_SEL_PLL          2'h2
`define BOOT_SEL_PLL_CRYSTAL_PIN     2'h3

`endif

// ---- shared/reset_boot_pkg.sv ----
// types shared by the reset and boot select block
package reset_boot_pkg;

  typedef enum logic [1:0] {
    CLK_SRC_EXTERNAL = 2'b00,
    CLK_SRC_ONCHIP   = 2'b01,
    CLK_SRC_CRYSTAL  = 2'b10
  } clock_source_e;

  typedef enum logic [1:0] {
    SEQ_HOLD    = 2'b00,
    SEQ_STRETCH = 2'b01,
    SEQ_RUN     = 2'b10
  } seq_state_e;

endpackage

// ---- testbench/board_model.sv ----
// board side: reset button, strap pins, shared crystal pin and oscillator levels
`timescale 1ns/10ps
module board_model (
  // clock and bench commands
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] low_len,
  input  wire logic [4:0] straps,
  // device pins
  input  wire logic       crystal_pin_out,
  input  wire logic       crystal_pin_oe,
  output logic            reset_in_n,
  output logic [1:0]      clock_boot_select,
  output logic            crystal_pin_in,
  output logic            reset_config_n,
  output logic            test_in,
  output logic [4:0]      osc
);
  logic [7:0] low_ff = 8'h00;
  logic [4:0] div_ff = 5'h00;
  always @(posedge pclk) begin
    if (go)
      low_ff <= low_len;
    else if (low_ff != 8'h00)
      low_ff <= low_ff - 8'h01;
  end
  always @(posedge pclk) div_ff <= div_ff + 5'h01;
  assign reset_in_n = (low_ff == 8'h00);
  assign clock_boot_select = straps[1:0];
  assign reset_config_n = straps[3];
  assign test_in = straps[4];
  // the device wins the pin while it drives it, else the board strap shows
  assign crystal_pin_in = crystal_pin_oe ? crystal_pin_out : straps[2];
  // distinct patterns so a wrong source selection shows up
  assign osc = {div_ff[1] ^ div_ff[3], div_ff[2], div_ff[1], div_ff[4], div_ff[0]};
endmodule

// ---- testbench/reset_and_clock_boot_select_chk.sv ----
// port assertions for the reset and clock boot select block
`timescale 1ns/10ps
module rcbs_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // reset pins
  input wire logic       reset_in_n,
  input wire logic       reset_out_n,
  input wire logic       core_reset_n,
  // straps and crystal pin
  input wire logic [1:0] clock_boot_select,
  input wire logic       reset_config_n,
  input wire logic       test_in,
  input wire logic       crystal_pin_in,
  input wire logic       crystal_pin_out,
  input wire logic       crystal_pin_oe,
  // clocks and modes
  input wire logic       osc_amp_level,
  input wire logic       onchip_osc_level,
  input wire logic       external_clock_in,
  input wire logic       crystal_osc_level,
  input wire logic       sys_clock_level,
  input wire logic       ref_clock_level,
  input wire logic       system_clock_out,
  input wire logic       pll_enable,
  input wire logic [1:0] clock_source,
  input wire logic       flash_prog_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles spent with the core free but the reset output still low
  logic [11:0] stretch_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stretch_ff <= 12'h000;
    else if (core_reset_n && !reset_out_n)
      stretch_ff <= stretch_ff + 12'h001;
    else
      stretch_ff <= 12'h000;
  end
  sequence held_low;
    !reset_in_n [*8];
  endsequence
  sequence boot_exit;
    !core_reset_n ##1 core_reset_n;
  endsequence
  a_filter_hold: assert property (held_low |-> ##[1:2] (!core_reset_n && !reset_out_n))
    else $error("reset input held low did not reset the core");
  a_out_follows: assert property (!core_reset_n |-> !reset_out_n)
    else $error("reset output high while core in reset");
  a_stretch_len: assert property ($rose(reset_out_n) |-> stretch_ff == 12'h400)
    else $error("reset output stretch length wrong");
  a_pll_latch: assert property (boot_exit |-> pll_enable == $past(clock_boot_select[1]))
    else $error("pll enable does not match captured select");
  a_src_decode: assert property (boot_exit |-> clock_source == ($past(clock_boot_select[0]) ?
    2'h2 : {1'b0, $past(crystal_pin_in)}))
    else $error("clock source does not match captured straps");
  a_flash_mode: assert property (boot_exit |->
    flash_prog_mode == (!$past(reset_config_n) && !$past(test_in)))
    else $error("flash programming mode wrong at reset exit");
  a_modes_held: assert property (core_reset_n && $past(core_reset_n) |-> $stable(pll_enable)
    && $stable(clock_source) && $stable(flash_prog_mode))
    else $error("boot modes changed outside reset");
  // live strap decides while the core is held, the latched select afterwards
  a_crystal_dir: assert property (crystal_pin_oe == !(core_reset_n ? pll_enable :
    clock_boot_select[1]) &&
    (!crystal_pin_oe || crystal_pin_out == osc_amp_level))
    else $error("crystal pin direction or level wrong");
  a_ext_ignored: assert property ($past(core_reset_n) && core_reset_n && clock_source == 2'h1
    |-> ref_clock_level == $past(onchip_osc_level))
    else $error("reference clock not from on-chip oscillator");
  a_ref_follow: assert property ($past(core_reset_n) && core_reset_n && clock_source != 2'h1
    |-> (clock_source == 2'h2 && ref_clock_level == $past(crystal_osc_level)) ||
    (clock_source == 2'h0 && ref_clock_level == $past(external_clock_in)))
    else $error("reference clock not from selected source");
  a_clock_mirror: assert property ($past(presetn) |->
    system_clock_out == $past(sys_clock_level))
    else $error("clock output does not follow system clock");
endmodule
bind reset_and_clock_boot_select rcbs_chk u_chk (.pclk(pclk), .presetn(presetn),
  .reset_in_n(reset_in_n), .reset_out_n(reset_out_n), .core_reset_n(core_reset_n),
  .clock_boot_select(clock_boot_select), .reset_config_n(reset_config_n), .test_in(test_in),
  .crystal_pin_in(crystal_pin_in), .crystal_pin_out(crystal_pin_out),
  .crystal_pin_oe(crystal_pin_oe), .osc_amp_level(osc_amp_level),
  .onchip_osc_level(onchip_osc_level), .sys_clock_level(sys_clock_level),
  .external_clock_in(external_clock_in), .crystal_osc_level(crystal_osc_level),
  .ref_clock_level(ref_clock_level), .system_clock_out(system_clock_out),
  .pll_enable(pll_enable), .clock_source(clock_source), .flash_prog_mode(flash_prog_mode));

// ---- testbench/tb.sv ----
// self-checking bench for the reset and clock boot select block
`timescale 1ns/10ps
module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        go = 1'b0;
  logic [7:0]  low_len = 8'h08;
  logic [4:0]  straps = 5'h08;
  logic [31:0] rd;
  logic [31:0] exp;
  logic        err;
  logic        x;
  int          n;
  int          n_fail = 0;
  int          n_compared = 0;
  wire  [31:0] prdata;
  wire  [1:0]  cbs, csrc;
  wire  [4:0]  osc;
  wire         pready, pslverr, reset_in_n, reset_out_n, core_reset_n, xo, xoe, xi;
  wire         rcn, tst, pll, refc, sco, fpm;
  always #10 pclk = ~pclk;
  reset_and_clock_boot_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_in_n(reset_in_n), .reset_out_n(reset_out_n),
    .core_reset_n(core_reset_n), .clock_boot_select(cbs), .reset_config_n(rcn),
    .test_in(tst), .crystal_pin_in(xi), .crystal_pin_out(xo), .crystal_pin_oe(xoe),
    .osc_amp_level(osc[4]), .external_clock_in(osc[3]), .onchip_osc_level(osc[2]),
    .crystal_osc_level(osc[1]), .sys_clock_level(osc[0]), .pll_enable(pll),
    .clock_source(csrc), .ref_clock_level(refc), .system_clock_out(sco),
    .flash_prog_mode(fpm));
  board_model u_board (.pclk(pclk), .go(go), .low_len(low_len), .straps(straps),
    .crystal_pin_out(xo), .crystal_pin_oe(xoe), .reset_in_n(reset_in_n),
    .clock_boot_select(cbs), .crystal_pin_in(xi), .reset_config_n(rcn), .test_in(tst),
    .osc(osc));
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    n_compared++;
    if (got !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic wait_for(input logic sel, input logic lvl, output int c);
    c = 0;
    while ((sel ? reset_out_n : core_reset_n) !== lvl && c < 3000) begin
      @(posedge pclk);
      #1;
      c++;
    end
    if (c >= 3000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic kick(input logic [7:0] len);
    @(posedge pclk);
    go <= 1'b1;
    low_len <= len;
    @(posedge pclk);
    go <= 1'b0;
  endtask
  // waits for the core to leave reset, then times the output stretch
  task automatic settle();
    wait_for(1'b0, 1'b1, n);
    wait_for(1'b1, 1'b1, n);
    chk("stretch", 32'h0000_0400, n);
  endtask
  task automatic boot(input logic [7:0] len);
    kick(len);
    wait_for(1'b0, 1'b0, n);
    settle();
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    for (int i = 0; i < 8; i++) begin
      straps <= {i[1] & ~i[0], i[0], i[2], i[1:0]};
      boot(8'h08);
      apb(1'b0, 32'h0000_0004, 32'h0000_0000);
      straps <= ~straps;
      x = i[1] ? i[2] : rd[8];
      exp = {23'h0, x, i[1:0], ~i[0] & ~i[1], i[0] ? 2'h2 : {1'b0, x}, i[1], 2'h3};
      chk("status", exp, rd);
      apb(1'b0, 32'h0000_0004, 32'h0000_0000);
      chk("status held", exp, rd);
      $display("strap case %0d done", i);
    end
    // back to the last strap case so later status reads expect the same value
    straps <= 5'h0F;
    kick(8'h07);
    n = 0;
    repeat (15) begin
      @(posedge pclk);
      #1;
      if (core_reset_n !== 1'b1 || reset_out_n !== 1'b1) n++;
    end
    chk("short pulse", 32'h0000_0000, n);
    kick(8'h08);
    wait_for(1'b0, 1'b0, n);
    wait_for(1'b0, 1'b1, n);
    repeat (100) @(posedge pclk);
    boot(8'h08);
    $display("reset filter and restart done");
    apb(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk("status read only", exp, rd);
    apb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, 32'h0000_0000, 32'h0000_0001);
    wait_for(1'b0, 1'b0, n);
    wait_for(1'b0, 1'b1, n);
    // counter starts at zero on entry; the read is loaded one cycle in
    apb(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk("stretch count", 32'h0000_0001, rd);
    wait_for(1'b1, 1'b1, n);
    chk("stretch rest", 32'h0000_0400 - 32'h0000_0003, n);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk("control cleared", 32'h0000_0000, rd);
    $display("register access done");
    conclude();
  end
endmodule
